// file: design/cgs_gain_steering.sv
// Colour gain steering, gain clip, black clamp and pixel output formatting
//
// Overview of operation
// RL1: Three-field mode: field index cycles 0,1,2.
// RL2: Field zero start selects slots 0/1 line.
// RL3: Field one start selects slots 2/3 line.
// RL4: Field two start selects slots 0/1 line.
// RL5: Line sync fall toggles line pattern (three-field).
// RL6: Four nine-bit colour gains in two registers.
// RL7: Variable gain 0.0351 dB per code plus 6.
// RL8: Combined gain clipped at exactly 42 dB.
// RL9: Eight-bit black target compared during clamp window.
// RL10: Filtered clamp correction, per line or slower.
// RL11: Mode bit D2 disables clamp; target becomes offset.
// RL12: Clamp window placed in shielded pixels, ideally 20+.
// RL13: Output latched at programmed phase.
// RL14: Control bit D4 makes output latches transparent.
// RL15: Control bit D3 three-states data outputs.
// RL16: Control bit D5 selects Gray coded output.
// RL17: Steering mode register selects three steering modes.
// RL18: Steering follows counter reset seven clocks after line sync.
// RL19: Within a line slots alternate, even first.
`default_nettype none
module cgs_gain_steering (
   input  wire logic                       core_clk,
   input  wire logic                       arst_n,
   input  wire logic                       sload_n,
   input  wire logic                       sclk,
   input  wire logic                       sdata,
   input  wire logic                       frame_sync,
   input  wire logic                       line_sync,
   input  wire logic                       clamp_window_pulse,
   input  wire logic                       adc_valid,
   input  wire logic [cgs_pkg::PIX_W-1:0]  adc_data,
   output logic                            adc_ready,
   input  wire logic                       dout_ready,
   output logic [cgs_pkg::PIX_W-1:0]       dout,
   output logic                            dout_oe,
   output logic                            dout_valid,
   output logic [1:0]                      field_index,
   output logic [1:0]                      gain_slot,
   output logic [cgs_pkg::CODE_W-1:0]      pixel_colour_gain_amp,
   output logic [cgs_pkg::VGA_W-1:0]       vga_gain,
   output logic [cgs_pkg::GAIN_W-1:0]      total_gain,
   output logic signed [cgs_pkg::CORR_W-1:0] clamp_offset
);
   typedef struct packed {
      logic                        clamp_off;
      logic [1:0]                  steer_mode;
      logic                        tristate;
      logic                        transparent;
      logic                        gray;
      logic [cgs_pkg::VGA_W-1:0]   vga;
      logic [cgs_pkg::CLAMP_W-1:0] clamp_level;
      logic [2*cgs_pkg::CODE_W-1:0] gain01;
      logic [2*cgs_pkg::CODE_W-1:0] gain23;
      logic [1:0]                  dout_phase;
      logic [3:0]                  clamp_rate;
      logic [2:0]                  fs_sync;
      logic [2:0]                  ls_sync;
      logic [1:0]                  cw_sync;
      logic [1:0]                  field_index;
      logic                        pending_upper;
      logic                        active_upper;
      logic                        hrun;
      logic [2:0]                  hcount;
      logic                        slot_odd;
      logic [1:0]                  phase;
      logic [3:0]                  line_count;
      logic                        cw_prev;
      logic signed [cgs_pkg::ACC_W-1:0]  acc;
      logic signed [cgs_pkg::CORR_W-1:0] corr;
      logic [cgs_pkg::PIX_W-1:0]   dout;
      logic                        dout_oe;
      logic                        dout_valid;
      logic [1:0]                  gain_slot;
      logic [cgs_pkg::CODE_W-1:0]  pga_code;
      logic [cgs_pkg::GAIN_W-1:0]  total_gain;
      logic signed [cgs_pkg::CORR_W-1:0] clamp_offset;
   } cgs_state_type;

   cgs_state_type              state_reg;
   cgs_state_type              state_next;
   cgs_pkg::cgs_reg_write_type reg_wr;
   logic                       buf_valid;
   logic [cgs_pkg::PIX_W-1:0]  buf_data;
   logic                       buf_take;
   logic [cgs_pkg::PIX_W-1:0]  coded_pixel;

   function automatic cgs_pkg::cgs_steer_mode_type decode_mode(input logic [1:0] bits);
      cgs_pkg::cgs_steer_mode_type m;
      m = cgs_pkg::CGS_PROGRESSIVE;
      if (bits == 2'h1) begin
         m = cgs_pkg::CGS_INTERLACED;
      end else if (bits == 2'h2) begin
         m = cgs_pkg::CGS_THREE_FIELD;
      end
      return m;
   endfunction

   function automatic logic [cgs_pkg::CODE_W-1:0] pick_code(
      input logic [2*cgs_pkg::CODE_W-1:0] pair,
      input logic                         odd
   );
      return odd ? pair[2*cgs_pkg::CODE_W-1:cgs_pkg::CODE_W] : pair[cgs_pkg::CODE_W-1:0];
   endfunction

   function automatic logic [cgs_pkg::PIX_W-1:0] to_gray(input logic [cgs_pkg::PIX_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   cgs_serial_port u_port (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .sload_n  (sload_n),
      .sclk     (sclk),
      .sdata    (sdata),
      .wr       (reg_wr)
   );

   assign coded_pixel = state_reg.gray ? to_gray(adc_data) : adc_data; // RL16

   cgs_pixel_buffer #(
      .WIDTH (cgs_pkg::PIX_W)
   ) u_buf (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .in_valid  (adc_valid),
      .in_data   (coded_pixel),
      .in_ready  (adc_ready),
      .out_valid (buf_valid),
      .out_data  (buf_data),
      .out_ready (buf_take)
   );

   // A stalled receiver holds the word in the buffer rather than dropping it
   assign buf_take = dout_ready
                     && (state_reg.transparent || state_reg.phase == state_reg.dout_phase); // RL13 RL14

   always_comb begin
      logic                        fs_fall;
      logic                        ls_fall;
      logic                        hreset;
      logic [1:0]                  next_field;
      logic signed [cgs_pkg::PIX_W:0] err;
      logic [cgs_pkg::CODE_W-1:0]  code;
      logic [31:0]                 pga_units;
      logic [31:0]                 vga_units;
      logic [31:0]                 sum_units;
      logic signed [cgs_pkg::CORR_W:0] corr_sum;
      state_next = state_reg;
      fs_fall = !state_reg.fs_sync[1] && state_reg.fs_sync[2];
      ls_fall = !state_reg.ls_sync[1] && state_reg.ls_sync[2];
      hreset = state_reg.hrun && state_reg.hcount == cgs_pkg::HRESET_CYCLES;
      next_field = state_reg.field_index;
      err = '0;
      code = '0;
      pga_units = '0;
      vga_units = '0;
      sum_units = '0;
      corr_sum = '0;

      // Register writes
      if (reg_wr.wr) begin
         unique case (reg_wr.addr)
            cgs_pkg::OPR_MODE_ADDR:
               state_next.clamp_off = reg_wr.data[cgs_pkg::OPR_CLAMP_OFF_BIT];
            cgs_pkg::STEER_MODE_ADDR: state_next.steer_mode = reg_wr.data[1:0]; // RL17
            cgs_pkg::AFE_CTL_ADDR: begin
               state_next.tristate = reg_wr.data[cgs_pkg::CTL_TRISTATE_BIT];
               state_next.transparent = reg_wr.data[cgs_pkg::CTL_TRANSPARENT_BIT];
               state_next.gray = reg_wr.data[cgs_pkg::CTL_GRAY_BIT];
            end
            cgs_pkg::VGA_GAIN_ADDR: state_next.vga = reg_wr.data[cgs_pkg::VGA_W-1:0];
            cgs_pkg::CLAMP_LEVEL_ADDR:
               state_next.clamp_level = reg_wr.data[cgs_pkg::CLAMP_W-1:0]; // RL9
            cgs_pkg::GAIN01_ADDR: state_next.gain01 = reg_wr.data[17:0]; // RL6
            cgs_pkg::GAIN23_ADDR: state_next.gain23 = reg_wr.data[17:0]; // RL6
            cgs_pkg::DOUT_PHASE_ADDR: state_next.dout_phase = reg_wr.data[1:0];
            cgs_pkg::CLAMP_RATE_ADDR: state_next.clamp_rate = reg_wr.data[3:0];
            default: ;
         endcase
      end

      // Pin synchronisers
      state_next.fs_sync = {state_reg.fs_sync[1:0], frame_sync};
      state_next.ls_sync = {state_reg.ls_sync[1:0], line_sync};
      state_next.cw_sync = {state_reg.cw_sync[0], clamp_window_pulse};

      // Field and line pattern; frame sync wins over a coincident line sync
      if (fs_fall) begin
         unique case (decode_mode(state_reg.steer_mode))
            cgs_pkg::CGS_PROGRESSIVE: next_field = 2'h0;
            cgs_pkg::CGS_INTERLACED: next_field = {1'b0, ~state_reg.field_index[0]};
            cgs_pkg::CGS_THREE_FIELD:
               next_field = (state_reg.field_index >= 2'h2) ? 2'h0
                            : state_reg.field_index + 2'h1; // RL1
         endcase
         state_next.field_index = next_field;
         state_next.pending_upper = (next_field == 2'h1); // RL2 RL3 RL4
      end else if (ls_fall) begin
         if (decode_mode(state_reg.steer_mode) == cgs_pkg::CGS_INTERLACED) begin
            state_next.pending_upper = state_reg.field_index[0];
         end else begin
            state_next.pending_upper = ~state_reg.pending_upper; // RL5
         end
      end

      // Horizontal counter reset delay
      if (ls_fall) begin
         state_next.hrun = 1'b1;
         state_next.hcount = 3'h1;
      end else if (hreset) begin
         state_next.hrun = 1'b0;
      end else if (state_reg.hrun) begin
         state_next.hcount = state_reg.hcount + 3'h1;
      end

      // Slot alternation within the line
      if (hreset) begin
         state_next.active_upper = state_reg.pending_upper; // RL18
         state_next.slot_odd = 1'b0; // RL19
         state_next.phase = 2'h0;
      end else begin
         state_next.slot_odd = ~state_reg.slot_odd; // RL19
         state_next.phase = state_reg.phase + 2'h1;
      end

      // Gain for the slot in use this pixel
      code = state_reg.active_upper ? pick_code(state_reg.gain23, state_reg.slot_odd)
                                    : pick_code(state_reg.gain01, state_reg.slot_odd);
      state_next.gain_slot = {state_reg.active_upper, state_reg.slot_odd};
      state_next.pga_code = code;
      pga_units = (32'(code) * cgs_pkg::PGA_STEP_SCALED) >> cgs_pkg::PGA_STEP_SHIFT;
      vga_units = 32'(state_reg.vga) * cgs_pkg::VGA_STEP_UNITS
                  + cgs_pkg::VGA_BASE_UNITS; // RL7
      sum_units = pga_units + vga_units;
      if (sum_units > cgs_pkg::GAIN_LIMIT_UNITS) begin
         sum_units = cgs_pkg::GAIN_LIMIT_UNITS; // RL8
      end
      state_next.total_gain = sum_units[cgs_pkg::GAIN_W-1:0];

      // Black clamp loop; runs on every (rate+1)th line
      if (hreset) begin
         state_next.line_count = (state_reg.line_count >= state_reg.clamp_rate) ? 4'h0
                                 : state_reg.line_count + 4'h1; // RL10
      end
      state_next.cw_prev = state_reg.cw_sync[1];
      if (state_reg.clamp_off) begin
         state_next.acc = '0;
         state_next.clamp_offset = cgs_pkg::CORR_W'({1'b0, state_reg.clamp_level}); // RL11
      end else begin
         if (state_reg.cw_sync[1] && state_reg.line_count == 4'h0 && adc_valid) begin
            err = signed'({5'h00, state_reg.clamp_level}) - signed'({1'b0, adc_data}); // RL9
            state_next.acc = state_reg.acc + cgs_pkg::ACC_W'(err);
         end
         if (!state_reg.cw_sync[1] && state_reg.cw_prev) begin
            // Filter gain trades settling speed against clamp noise
            corr_sum = (cgs_pkg::CORR_W+1)'(state_reg.corr)
                       + (cgs_pkg::CORR_W+1)'(state_reg.acc >>> cgs_pkg::CLAMP_FILTER_SHIFT);
            if (corr_sum[cgs_pkg::CORR_W] != corr_sum[cgs_pkg::CORR_W-1]) begin
               state_next.corr = corr_sum[cgs_pkg::CORR_W] ? {1'b1, {(cgs_pkg::CORR_W-1){1'b0}}}
                                 : {1'b0, {(cgs_pkg::CORR_W-1){1'b1}}};
            end else begin
               state_next.corr = corr_sum[cgs_pkg::CORR_W-1:0]; // RL10
            end
            state_next.acc = '0;
         end
         state_next.clamp_offset = state_reg.corr; // RL10
      end

      // Output latch
      state_next.dout_valid = 1'b0;
      if (buf_take && buf_valid) begin
         state_next.dout = buf_data; // RL13 RL14
         state_next.dout_valid = 1'b1;
      end
      state_next.dout_oe = ~state_reg.tristate; // RL15
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '{vga: cgs_pkg::VGA_RESET,
                        clamp_level: cgs_pkg::CLAMP_LEVEL_RESET,
                        gain01: cgs_pkg::GAIN_PAIR_RESET,
                        gain23: cgs_pkg::GAIN_PAIR_RESET,
                        dout_phase: cgs_pkg::DOUT_PHASE_RESET,
                        clamp_rate: cgs_pkg::CLAMP_RATE_RESET,
                        fs_sync: 3'h7,
                        ls_sync: 3'h7,
                        total_gain: cgs_pkg::VGA_BASE_UNITS[cgs_pkg::GAIN_W-1:0],
                        dout_oe: 1'b1,
                        default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign dout = state_reg.dout;
   assign dout_oe = state_reg.dout_oe;
   assign dout_valid = state_reg.dout_valid;
   assign field_index = state_reg.field_index;
   assign gain_slot = state_reg.gain_slot;
   assign pixel_colour_gain_amp = state_reg.pga_code;
   assign vga_gain = state_reg.vga;
   assign total_gain = state_reg.total_gain;
   assign clamp_offset = state_reg.clamp_offset;
endmodule
`default_nettype wire

// file: design/cgs_pkg.sv
// Shared constants and types for the colour gain steering and output block
`default_nettype none
package cgs_pkg;
   localparam int PIX_W = 12;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 24;
   localparam int FRAME_BITS = 32;
   localparam int CODE_W = 9;
   localparam int VGA_W = 10;
   localparam int CLAMP_W = 8;
   localparam int CORR_W = 14;
   localparam int ACC_W = 20;
   localparam int GAIN_W = 19;
   // Register offsets on the serial port
   localparam logic [7:0] OPR_MODE_ADDR = 8'h00;
   localparam logic [7:0] STEER_MODE_ADDR = 8'h03;
   localparam logic [7:0] AFE_CTL_ADDR = 8'h04;
   localparam logic [7:0] VGA_GAIN_ADDR = 8'h05;
   localparam logic [7:0] CLAMP_LEVEL_ADDR = 8'h06;
   localparam logic [7:0] GAIN01_ADDR = 8'h07;
   localparam logic [7:0] GAIN23_ADDR = 8'h08;
   localparam logic [7:0] DOUT_PHASE_ADDR = 8'h09;
   localparam logic [7:0] CLAMP_RATE_ADDR = 8'h0A;
   // Field positions
   localparam int OPR_CLAMP_OFF_BIT = 2;
   localparam int CTL_TRISTATE_BIT = 3;
   localparam int CTL_TRANSPARENT_BIT = 4;
   localparam int CTL_GRAY_BIT = 5;
   // Reset values
   localparam logic [VGA_W-1:0] VGA_RESET = 10'h000;
   localparam logic [CLAMP_W-1:0] CLAMP_LEVEL_RESET = 8'h00;
   localparam logic [2*CODE_W-1:0] GAIN_PAIR_RESET = 18'h00000;
   localparam logic [1:0] DOUT_PHASE_RESET = 2'h0;
   localparam logic [3:0] CLAMP_RATE_RESET = 4'h0;
   // Timing: horizontal counter reset follows line sync fall by this many clocks
   localparam logic [2:0] HRESET_CYCLES = 3'h7;
   // Gain arithmetic in units of 0.0001 dB
   localparam logic [31:0] VGA_STEP_UNITS = 32'h0000015F;
   localparam logic [31:0] VGA_BASE_UNITS = 32'h0000EA60;
   localparam logic [31:0] PGA_STEP_SCALED = 32'h00058100;
   localparam int PGA_STEP_SHIFT = 10;
   localparam logic [31:0] GAIN_LIMIT_UNITS = 32'h000668A0;
   localparam int CLAMP_FILTER_SHIFT = 4;

   typedef enum logic [1:0] {
      CGS_PROGRESSIVE,
      CGS_INTERLACED,
      CGS_THREE_FIELD
   } cgs_steer_mode_type;

   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } cgs_reg_write_type;

   typedef struct packed {
      logic             valid;
      logic [PIX_W-1:0] data;
   } cgs_pixel_type;
endpackage
`default_nettype wire

// file: design/cgs_serial_port.sv
// Three-wire serial register port: address then data, LSB first
`default_nettype none
module cgs_serial_port (
   input  wire logic                      core_clk,
   input  wire logic                      arst_n,
   input  wire logic                      sload_n,
   input  wire logic                      sclk,
   input  wire logic                      sdata,
   output var  cgs_pkg::cgs_reg_write_type wr
);
   typedef struct packed {
      logic [2:0]  load_sync;
      logic [2:0]  clk_sync;
      logic [1:0]  dat_sync;
      logic [5:0]  count;
      logic [31:0] shift;
      cgs_pkg::cgs_reg_write_type wr;
   } cgs_sp_state_type;

   cgs_sp_state_type state_reg;
   cgs_sp_state_type state_next;

   always_comb begin
      state_next = state_reg;
      state_next.load_sync = {state_reg.load_sync[1:0], sload_n};
      state_next.clk_sync = {state_reg.clk_sync[1:0], sclk};
      state_next.dat_sync = {state_reg.dat_sync[0], sdata};
      state_next.wr.wr = 1'b0;
      if (state_reg.load_sync[2]) begin
         // Idle between frames; count restarts on the next load fall
         state_next.count = 6'h00;
      end else if (state_reg.clk_sync[1] && !state_reg.clk_sync[2]
                   && state_reg.count < 6'(cgs_pkg::FRAME_BITS)) begin
         state_next.shift = {state_reg.dat_sync[1], state_reg.shift[31:1]};
         state_next.count = state_reg.count + 6'h01;
      end
      // Short frames are dropped, extra bits beyond a word are ignored
      if (state_reg.load_sync[1] && !state_reg.load_sync[2]
          && state_reg.count == 6'(cgs_pkg::FRAME_BITS)) begin
         state_next.wr.wr = 1'b1;
         state_next.wr.addr = state_reg.shift[7:0];
         state_next.wr.data = state_reg.shift[31:8];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '{load_sync: 3'h7, clk_sync: 3'h0, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign wr = state_reg.wr;
endmodule
`default_nettype wire

// file: design/cgs_pixel_buffer.sv
// Two-entry pixel buffer with valid and ready on both sides
`default_nettype none
module cgs_pixel_buffer #(
   parameter int WIDTH = 12
) (
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic                  head;
      logic [1:0]            count;
      logic                  ready;
   } cgs_buf_state_type;

   cgs_buf_state_type state_reg;
   cgs_buf_state_type state_next;
   logic              push;
   logic              pop;

   always_comb begin
      push = in_valid && state_reg.ready;
      pop = out_ready && (state_reg.count != 2'h0);
      state_next = state_reg;
      if (push) begin
         state_next.mem[state_reg.head ^ (state_reg.count != 2'h0)] = in_data;
      end
      if (pop) begin
         state_next.head = ~state_reg.head;
      end
      state_next.count = state_reg.count + 2'(push) - 2'(pop);
      // Ready is registered so the upstream sees a clean flop
      state_next.ready = (state_next.count != 2'h2);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '{ready: 1'b1, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign in_ready = state_reg.ready;
   assign out_valid = (state_reg.count != 2'h0);
   assign out_data = state_reg.mem[state_reg.head];
endmodule
`default_nettype wire

// file: tb/cgs_props.sv
// Port assertions for the gain steering block
`default_nettype none
module cgs_props (
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic        frame_sync,
   input wire logic        line_sync,
   input wire logic        dout_ready,
   input wire logic        dout_valid,
   input wire logic [11:0] dout,
   input wire logic [1:0]  field_index,
   input wire logic [1:0]  gain_slot,
   input wire logic [18:0] total_gain
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  pin_q_reg;
   logic [15:0] frm_reg;
   logic [15:0] any_reg;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Recent pin falls, wide enough to cover sync plus counter reset delay
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_q_reg <= 2'h3;
         frm_reg <= 16'h0;
         any_reg <= 16'h0;
      end else begin
         pin_q_reg <= {line_sync, frame_sync};
         frm_reg <= {frm_reg[14:0], pin_q_reg[0] & ~frame_sync};
         any_reg <= {any_reg[14:0], (pin_q_reg[0] & ~frame_sync) | (pin_q_reg[1] & ~line_sync)};
      end
   end
   gain_cap_a: assert property (total_gain <= 19'h668A0)
      else $error("total gain above limit");
   gain_floor_a: assert property (total_gain >= 19'h0EA60)
      else $error("total gain below floor");
   field_range_a: assert property (field_index != 2'h3)
      else $error("field index out of range");
   field_step_a: assert property ($changed(field_index) |->
      field_index == 2'h0 || field_index == $past(field_index) + 2'h1)
      else $error("field index skipped");
   field_cause_a: assert property ($changed(field_index) |-> |frm_reg)
      else $error("field change without frame fall");
   slot_even_a: assert property ($past(gain_slot[0]) |-> !gain_slot[0])
      else $error("odd slot not followed by even");
   pattern_cause_a: assert property ($changed(gain_slot[1]) |-> any_reg[10])
      else $error("line pattern change without sync fall");
   valid_ready_a: assert property (dout_valid |-> $past(dout_ready))
      else $error("word sent while receiver stalled");
   dout_hold_a: assert property (!dout_valid |-> $stable(dout))
      else $error("output word changed without valid");
endmodule
`default_nettype wire

// file: tb/cgs_asic_model.sv
// Downstream image processor model taking pixel words
`default_nettype none
module cgs_asic_model (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic [1:0]  stall,
   input  wire logic        dout_valid,
   input  wire logic        dout_oe,
   input  wire logic [11:0] dout,
   output logic             dout_ready,
   output logic             got,
   output logic [11:0]      word
);
   timeunit 1ns;
   timeprecision 1ps;
   // Stall 0 always ready, 1 random stalls, 2 stalled
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dout_ready <= 1'h0;
         got <= 1'h0;
      end else begin
         dout_ready <= stall == 2'h0 || (stall == 2'h1 && $urandom_range(1) == 1);
         got <= dout_valid && dout_oe;
         word <= dout;
      end
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the gain steering block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic              core_clk = 1'h0, arst_n = 1'h0, sload_n = 1'h1, sclk = 1'h0;
   logic              sdata = 1'h0, frame_sync = 1'h1, line_sync = 1'h1;
   logic              clamp_window_pulse = 1'h0, adc_valid = 1'h0, gray_on = 1'h0;
   logic [11:0]       adc_data = 12'h0, dout, word;
   logic [1:0]        stall = 2'h0, field_index, gain_slot;
   logic              adc_ready, dout_ready, dout_oe, dout_valid, got;
   logic [8:0]        code;
   logic [9:0]        vga_gain;
   logic [18:0]       total_gain;
   logic signed [13:0] clamp_offset;
   logic [11:0]       exp_q[$];
   int                num_errors = 0, n_tests = 0;
   cgs_gain_steering i_cgs_gain_steering (.core_clk(core_clk), .arst_n(arst_n),
      .sload_n(sload_n), .sclk(sclk), .sdata(sdata), .frame_sync(frame_sync),
      .line_sync(line_sync), .clamp_window_pulse(clamp_window_pulse),
      .adc_valid(adc_valid), .adc_data(adc_data), .adc_ready(adc_ready),
      .dout_ready(dout_ready), .dout(dout), .dout_oe(dout_oe), .dout_valid(dout_valid),
      .field_index(field_index), .gain_slot(gain_slot), .pixel_colour_gain_amp(code),
      .vga_gain(vga_gain), .total_gain(total_gain), .clamp_offset(clamp_offset));
   cgs_asic_model i_cgs_asic_model (.core_clk(core_clk), .arst_n(arst_n), .stall(stall),
      .dout_valid(dout_valid), .dout_oe(dout_oe), .dout(dout), .dout_ready(dout_ready),
      .got(got), .word(word));
   always #5 core_clk = ~core_clk;
   task automatic chk(string name, logic [31:0] exp, logic [31:0] seen);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [11:0] gray(logic [11:0] w);
      return w ^ (w >> 1);
   endfunction
   function automatic logic [31:0] gain_exp(int c, int v);
      int g = 32'hEA60 + 32'h15F * v + (c * 32'h581) / 4;
      return g > 32'h668A0 ? 32'h668A0 : g;
   endfunction
   // Address then data, LSB first; slow sclk so the synchroniser sees every edge
   task automatic ser_wr(logic [7:0] a, logic [23:0] d);
      logic [31:0] f = {d, a};
      sload_n <= 1'h0;
      for (int i = 0; i < 32; i++) begin
         sdata <= f[i];
         repeat (3) @(posedge core_clk);
         sclk <= 1'h1;
         repeat (3) @(posedge core_clk);
         sclk <= 1'h0;
      end
      repeat (3) @(posedge core_clk);
      sload_n <= 1'h1;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic sync_fall(logic frm, logic ln);
      frame_sync <= !frm;
      line_sync <= !ln;
      repeat (3) @(posedge core_clk);
      frame_sync <= 1'h1;
      line_sync <= 1'h1;
      repeat (20) @(posedge core_clk);
   endtask
   task automatic stream(int n);
      for (int i = 0; i < n; i++) begin
         adc_data <= 12'($urandom);
         adc_valid <= 1'h1;
         @(posedge core_clk);
         while (adc_ready !== 1'h1) @(posedge core_clk);
         exp_q.push_back(gray_on ? gray(adc_data) : adc_data);
      end
      adc_valid <= 1'h0;
      for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge core_clk);
      chk("words left", 32'h0, exp_q.size());
   endtask
   always @(posedge core_clk) if (got === 1'h1) chk("pixel", exp_q.pop_front(), word);
   initial begin
      int c;
      int v;
      void'($urandom(32'h3646));
      repeat (12) @(posedge core_clk);
      arst_n <= 1'h1;
      chk("gain", 32'hEA60, total_gain);
      ser_wr(8'h03, 24'h2);
      for (int f = 1; f < 5; f++) begin
         sync_fall(1'h1, 1'h1);
         chk("field", f % 3, field_index);
         chk("line", f % 3 == 1, gain_slot[1]);
         sync_fall(1'h0, 1'h1);
         chk("toggle", f % 3 != 1, gain_slot[1]);
      end
      ser_wr(8'h03, 24'h1);
      sync_fall(1'h1, 1'h1);
      chk("field", 32'h0, field_index);
      sync_fall(1'h1, 1'h1);
      chk("line", 32'h1, gain_slot[1]);
      ser_wr(8'h03, 24'h0);
      sync_fall(1'h1, 1'h1);
      chk("field", 32'h0, field_index);
      $display("steering test done");
      for (int i = 0; i < 6; i++) begin
         c = i == 0 ? 0 : i == 1 ? 511 : $urandom_range(511);
         v = i == 0 ? 0 : i == 1 ? 1023 : $urandom_range(1023);
         ser_wr(8'h05, 24'(v));
         ser_wr(8'h07, 24'({c[8:0], c[8:0]}));
         ser_wr(8'h08, 24'({c[8:0], c[8:0]}));
         chk("vga", v, vga_gain);
         chk("code", c, code);
         chk("gain", gain_exp(c, v), total_gain);
      end
      $display("gain test done");
      stall <= 2'h1;
      stream(20);
      ser_wr(8'h04, 24'h30);
      gray_on = 1'h1;
      stream(20);
      stall <= 2'h2;
      // Stalled receiver: the buffer must refuse rather than drop a word
      fork
         stream(3);
         begin
            repeat (30) @(posedge core_clk);
            chk("adc ready", 32'h0, adc_ready);
            stall <= 2'h0;
         end
      join
      ser_wr(8'h04, 24'h08);
      chk("oe", 32'h0, dout_oe);
      ser_wr(8'h04, 24'h00);
      chk("oe", 32'h1, dout_oe);
      $display("output test done");
      v = $urandom_range(255);
      ser_wr(8'h06, 24'(v));
      ser_wr(8'h00, 24'h04);
      clamp_window_pulse <= 1'h1;
      repeat (24) @(posedge core_clk);
      clamp_window_pulse <= 1'h0;
      repeat (4) @(posedge core_clk);
      chk("clamp", v, clamp_offset);
      $display("clamp test done");
      summarize();
   end
   initial begin
      #500us;
      num_errors++;
      summarize();
   end
endmodule
bind cgs_gain_steering cgs_props i_cgs_props (.core_clk(core_clk), .arst_n(arst_n),
   .frame_sync(frame_sync), .line_sync(line_sync), .dout_ready(dout_ready),
   .dout_valid(dout_valid), .dout(dout), .field_index(field_index),
   .gain_slot(gain_slot), .total_gain(total_gain));
`default_nettype wire
